// ===== shared/tcw_pkg.sv
// Purpose: constants for the timer compare and waveform block
// Assumes: one clock, timer advances on a count enable input
// Notes: mode and field encodings shared by all design files
//
// Summary of operation
// - Nonzero output mode overrides port pin value
// - Direction bit alone decides pin drive
// - Override depends only on output mode bits
// - Output mode zero leaves state unchanged
// - Mode change acts next match; non-PWM force acts now
// - Count sequence depends only on waveform mode
// - Normal mode increments, wraps 0xff to 0x00
// - Normal overflow flag set when counter hits zero
// - Clear-on-match clears counter at compare A
// - Clear-on-match compare A unbuffered, may wrap
// - Clear-on-match raises compare flag A at top
// - Clear-on-match mode 1 toggles at each match
// - Clear-on-match overflow set passing max to zero
// - Fast PWM counts zero to top, restarts
// - Non-inverting clears at match, sets at bottom
// - Fast PWM: two non-inverted, three inverted
// - Counter clears cycle after top; bottom action
// - Fast PWM overflow flag set at top
// - Fixed top period is 256 timer clocks
// - Compare zero spikes; compare max constant level
// - Fast PWM mode 1 toggles, buffer kept
// - Output state separate, settable before enable
// - Non-PWM force updates state, no flag, no clear
// - PWM compare writes buffered, others direct
package tcw_pkg;
  localparam logic [2:0] WGM_NORMAL   = 3'h0;
  localparam logic [2:0] WGM_CLEAR    = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_FAST_A   = 3'h7;
  localparam logic [1:0] COM_OFF      = 2'h0;
  localparam logic [1:0] COM_TOGGLE   = 2'h1;
  localparam logic [1:0] COM_CLEAR    = 2'h2;
  localparam logic [1:0] COM_SET      = 2'h3;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic       STATE_RESET  = 1'b0;
  localparam logic [8:0] FIXED_PERIOD = 9'h100; // Fast PWM period at top = max
  typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} tcw_action_type;
endpackage

// ===== hdl/tcw_compare_channel.sv
// Purpose: one compare channel: buffer, match detect and output state
// Assumes: count_enable is the timer clock enable
// Notes: output state kept apart from the pin
`timescale 1ns/1ps
module tcw_compare_channel import tcw_pkg::*; (
  input  wire logic       clock,             // System clock
  input  wire logic       srst,              // Synchronous reset
  input  wire logic       count_enable,      // Timer clock enable
  input  wire logic [2:0] waveform_mode_select, // Waveform mode
  input  wire logic [1:0] compare_output_mode_bits, // Output mode
  input  wire logic [7:0] counter_value,     // Current count
  input  wire logic       at_top,            // Counter at top
  input  wire logic       at_bottom_clear,   // Counter clearing to bottom
  input  wire logic       match_block,       // Match blocked this cycle
  input  wire logic       compare_write,     // Compare value write strobe
  input  wire logic [7:0] compare_wdata,     // Compare write data
  input  wire logic       force_compare_strobe, // Force match strobe
  input  wire logic       state_write,       // Preset output state
  input  wire logic       state_wdata,       // Preset value
  output logic      [7:0] compare_value,     // Active compare value
  output logic      [7:0] compare_buffer,    // Buffered write value
  output logic            match,             // Real match, one cycle
  output logic            compare_output_state // Internal output state
);
  logic pwm_mode;
  logic [7:0] compare_buffer_reg;
  logic [7:0] compare_value_reg;
  logic state_reg;
  logic state_next;
  tcw_action_type match_action;
  tcw_action_type bottom_action;

  assign pwm_mode = (waveform_mode_select == WGM_FAST_MAX) || (waveform_mode_select == WGM_FAST_A);

  // Buffer update; PWM loads active value at top to avoid odd pulses
  always_ff @(posedge clock) begin
    if (srst) begin
      compare_buffer_reg <= COMPARE_RESET;
      compare_value_reg  <= COMPARE_RESET;
    end else begin
      if (compare_write) begin
        compare_buffer_reg <= compare_wdata;
      end
      if (!pwm_mode && compare_write) begin
        compare_value_reg <= compare_wdata;
      end else if (pwm_mode && count_enable && at_top) begin
        compare_value_reg <= compare_buffer_reg;
      end
    end
  end

  // Match on timer tick only, suppressed after a counter write
  assign match = count_enable && !match_block && (counter_value == compare_value_reg);

  // Action selection; mode bits read live so a change acts at next match
  always_comb begin
    match_action  = ACT_NONE;
    bottom_action = ACT_NONE;
    case (compare_output_mode_bits)
      COM_OFF: match_action = ACT_NONE;
      COM_TOGGLE: match_action = ACT_TOGGLE;
      COM_CLEAR: begin
        match_action = ACT_CLEAR;
        if (pwm_mode) begin
          bottom_action = ACT_SET;
        end
      end
      default: begin
        match_action = ACT_SET;
        if (pwm_mode) begin
          bottom_action = ACT_CLEAR;
        end
      end
    endcase
  end

  // Next output state; match wins over bottom so compare max holds level
  always_comb begin
    state_next = state_reg;
    if (count_enable && at_bottom_clear) begin
      if (bottom_action == ACT_SET) begin
        state_next = 1'b1;
      end else if (bottom_action == ACT_CLEAR) begin
        state_next = 1'b0;
      end
    end
    if (match || (force_compare_strobe && !pwm_mode)) begin
      case (match_action)
        ACT_TOGGLE: state_next = !state_reg;
        ACT_CLEAR:  state_next = 1'b0;
        ACT_SET:    state_next = 1'b1;
        default:    state_next = state_next;
      endcase
    end
  end

  // Output state register, presettable before pin enable
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= STATE_RESET;
    end else if (state_write) begin
      state_reg <= state_wdata;
    end else begin
      state_reg <= state_next;
    end
  end

  assign compare_value        = compare_value_reg;
  assign compare_buffer       = compare_buffer_reg;
  assign compare_output_state = state_reg;
endmodule

// ===== hdl/tcw_pin_override.sv
// Purpose: port pin source select for the compare output
// Assumes: port data and direction come from port registers
// Notes: waveform mode plays no part here
`timescale 1ns/1ps
module tcw_pin_override import tcw_pkg::*; (
  input  wire logic       clock,             // System clock
  input  wire logic       srst,              // Synchronous reset
  input  wire logic [1:0] compare_output_mode_bits, // Output mode
  input  wire logic       compare_output_state, // Internal state
  input  wire logic       port_data,         // Normal port output value
  input  wire logic       port_direction,    // 1 selects output
  output logic            pin_out,           // Pin output level
  output logic            pin_oe_n           // Low while driving
);
  logic pin_out_reg;
  logic pin_oe_n_reg;

  // Registered pin drive; tristate at reset like a port pin
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_out_reg  <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_out_reg  <= (compare_output_mode_bits != COM_OFF) ? compare_output_state : port_data;
      pin_oe_n_reg <= !port_direction;
    end
  end

  assign pin_out  = pin_out_reg;
  assign pin_oe_n = pin_oe_n_reg;
endmodule

// ===== hdl/tcw_timer.sv
// Purpose: 8-bit timer with normal, clear-on-match and fast PWM modes
// Assumes: count_enable pulses once per prescaled timer clock
// Notes: channel A drives the pin; flags cleared by pulse inputs
`timescale 1ns/1ps
module tcw_timer import tcw_pkg::*; (
  input  wire logic       clock,             // 40 MHz system clock
  input  wire logic       srst,              // Synchronous reset
  input  wire logic       count_enable,      // Timer clock enable
  input  wire logic [2:0] waveform_mode_select, // Waveform mode
  input  wire logic [1:0] channel_a_output_mode_bits, // Channel A mode
  input  wire logic       counter_write,     // Counter write strobe
  input  wire logic [7:0] counter_wdata,     // Counter write data
  input  wire logic       compare_write,     // Compare A write strobe
  input  wire logic [7:0] compare_wdata,     // Compare A write data
  input  wire logic       force_compare_strobe, // Force match A
  input  wire logic       state_write,       // Preset output state A
  input  wire logic       state_wdata,       // Preset value
  input  wire logic       overflow_clear,    // Clear overflow flag
  input  wire logic       compare_clear,     // Clear compare flag A
  input  wire logic       port_data,         // Port output value
  input  wire logic       port_direction,    // Port direction bit
  output logic      [7:0] counter_value,     // Counter value
  output logic      [7:0] compare_value_a,   // Active compare A
  output logic      [7:0] compare_buffer_a,  // Buffered compare A
  output logic            overflow_flag,     // Overflow flag
  output logic            compare_flag_a,    // Compare flag A
  output logic            channel_a_output_state, // Output state A
  output logic            pin_out,           // Pin output level
  output logic            pin_oe_n           // Pin output enable, low
);
  logic [7:0] counter_reg;
  logic [7:0] counter_next;
  logic [7:0] top_value;
  logic       at_top;
  logic       at_bottom_clear;
  logic       fast_mode;
  logic       clear_mode;
  logic       match_a;
  logic       match_block_reg;
  logic       overflow_reg;
  logic       compare_flag_reg;
  logic       overflow_event;
  logic       compare_event_reg;

  // Mode decode from waveform select only; output mode never counted in
  assign fast_mode  = (waveform_mode_select == WGM_FAST_MAX) || (waveform_mode_select == WGM_FAST_A);
  assign clear_mode = (waveform_mode_select == WGM_CLEAR);
  assign top_value  = (waveform_mode_select == WGM_FAST_MAX) ? COUNT_MAX : compare_value_a;
  assign at_top     = fast_mode ? (counter_reg == top_value) : (counter_reg == COUNT_MAX);
  assign at_bottom_clear = fast_mode && at_top;

  // Count sequence
  always_comb begin
    counter_next = counter_reg + 8'h01;
    if (fast_mode && at_top) begin
      counter_next = COUNT_BOTTOM;
    end else if (clear_mode && match_a) begin
      counter_next = COUNT_BOTTOM;
    end
  end

  // Counter register; a write beats any count or clear
  always_ff @(posedge clock) begin
    if (srst) begin
      counter_reg <= COUNT_RESET;
    end else if (counter_write) begin
      counter_reg <= counter_wdata;
    end else if (count_enable) begin
      counter_reg <= counter_next;
    end
  end

  // Block the match on the first tick after a counter write; held until that tick
  always_ff @(posedge clock) begin
    if (srst) begin
      match_block_reg <= 1'b0;
    end else if (counter_write) begin
      match_block_reg <= 1'b1;
    end else if (count_enable) begin
      match_block_reg <= 1'b0;
    end
  end

  // Overflow: wrap in normal or clear mode, top in fast PWM
  assign overflow_event = count_enable && !counter_write &&
                          (fast_mode ? at_top : (counter_reg == COUNT_MAX));

  // Overflow flag; set beats clear so no event is lost
  always_ff @(posedge clock) begin
    if (srst) begin
      overflow_reg <= 1'b0;
    end else if (overflow_event) begin
      overflow_reg <= 1'b1;
    end else if (overflow_clear) begin
      overflow_reg <= 1'b0;
    end
  end

  // Compare flag set two clocks after the match; forcing never sets it
  always_ff @(posedge clock) begin
    if (srst) begin
      compare_event_reg <= 1'b0;
    end else begin
      compare_event_reg <= match_a;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      compare_flag_reg <= 1'b0;
    end else if (compare_event_reg) begin
      compare_flag_reg <= 1'b1;
    end else if (compare_clear) begin
      compare_flag_reg <= 1'b0;
    end
  end

  // Channel A compare and output state
  tcw_compare_channel u_channel_a (
    .clock                    (clock),
    .srst                     (srst),
    .count_enable             (count_enable),
    .waveform_mode_select     (waveform_mode_select),
    .compare_output_mode_bits (channel_a_output_mode_bits),
    .counter_value            (counter_reg),
    .at_top                   (at_top),
    .at_bottom_clear          (at_bottom_clear),
    .match_block              (match_block_reg || counter_write),
    .compare_write            (compare_write),
    .compare_wdata            (compare_wdata),
    .force_compare_strobe     (force_compare_strobe),
    .state_write              (state_write),
    .state_wdata              (state_wdata),
    .compare_value            (compare_value_a),
    .compare_buffer           (compare_buffer_a),
    .match                    (match_a),
    .compare_output_state     (channel_a_output_state)
  );

  // Pin source and direction
  tcw_pin_override u_pin (
    .clock                    (clock),
    .srst                     (srst),
    .compare_output_mode_bits (channel_a_output_mode_bits),
    .compare_output_state     (channel_a_output_state),
    .port_data                (port_data),
    .port_direction           (port_direction),
    .pin_out                  (pin_out),
    .pin_oe_n                 (pin_oe_n)
  );

  assign counter_value  = counter_reg;
  assign overflow_flag  = overflow_reg;
  assign compare_flag_a = compare_flag_reg;
endmodule

// ===== test/tcw_timer_properties.sv
// Purpose: port checks for the timer compare block
// Assumes: counter writes only in normal mode with the tick low
// Notes: bound into tcw_timer below
`timescale 1ns/1ps
module tcw_timer_checker import tcw_pkg::*; (
  input wire logic       clock, // Clock
  input wire logic       srst, // Reset
  input wire logic       count_enable, // Tick
  input wire logic [2:0] waveform_mode_select, // Mode
  input wire logic [1:0] channel_a_output_mode_bits, // Output mode
  input wire logic       force_compare_strobe, // Force
  input wire logic       state_write, // Preset
  input wire logic       port_data, // Port value
  input wire logic       port_direction, // Direction
  input wire logic [7:0] counter_value, // Count
  input wire logic [7:0] compare_value_a, // Compare
  input wire logic       overflow_flag, // Overflow
  input wire logic       compare_flag_a, // Match flag
  input wire logic       channel_a_output_state, // State
  input wire logic       pin_out, // Pin
  input wire logic       pin_oe_n // Pin enable
);
  // Short aliases keep the properties readable
  wire [2:0] wm = waveform_mode_select;
  wire [1:0] om = channel_a_output_mode_bits;
  wire [7:0] cv = counter_value;
  wire       st = channel_a_output_state;
  wire       hit = count_enable && cv == compare_value_a;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // Count back at bottom, match flag one clock later
  sequence clr_then_flag;
    cv == COUNT_BOTTOM ##1 compare_flag_a;
  endsequence
  // Pin registers lag a clock; the edge after reset is skipped
  a_pin_enable: assert property (
    !$past(srst) |-> pin_oe_n == !$past(port_direction)) else $error("pin enable wrong");
  a_pin_source: assert property (
    !$past(srst) |-> pin_out == ($past(om) != COM_OFF ? $past(st) : $past(port_data))) else $error("pin source wrong");
  a_normal_count: assert property (
    wm == WGM_NORMAL && count_enable |=> cv == $past(cv) + 8'h01 && (cv != COUNT_BOTTOM || overflow_flag))
    else $error("normal count wrong");
  a_ctc_clear: assert property (
    wm == WGM_CLEAR && hit |=> clr_then_flag) else $error("match clear wrong");
  a_ctc_toggle: assert property (
    wm == WGM_CLEAR && om == COM_TOGGLE && hit && !state_write |=> st != $past(st)) else $error("toggle wrong");
  a_fast_top: assert property (
    count_enable && (wm == WGM_FAST_MAX && cv == COUNT_MAX || wm == WGM_FAST_A && cv == compare_value_a)
    |=> cv == COUNT_BOTTOM && overflow_flag) else $error("fast top wrong");
  // Match action wins over the bottom action in the same tick
  a_pwm_level: assert property (
    wm == WGM_FAST_MAX && om[1] && count_enable && (hit || cv == COUNT_MAX) && !state_write
    |=> st == (($past(om) == COM_SET) ^ ($past(cv) != $past(compare_value_a)))) else $error("pwm level wrong");
  a_force_only: assert property (
    wm == WGM_NORMAL && om == COM_TOGGLE && force_compare_strobe && !count_enable && !state_write
    |=> st != $past(st) && $stable(cv) ##1 !$rose(compare_flag_a)) else $error("force wrong");
endmodule
bind tcw_timer tcw_timer_checker chk (.*);

// ===== test/tcw_pin_load.sv
// Purpose: port pin with its external load
// Assumes: a pull-up holds the pad when undriven
// Notes: pull level differs from the low drive level
`timescale 1ns/1ps
module tcw_pin_load (
  input  wire logic pin_out,  // Drive level
  input  wire logic pin_oe_n, // Low drives
  output logic      pad_level // Pad level
);
  // Undriven pad rests at the pull-up level
  assign pad_level = pin_oe_n ? 1'b1 : pin_out;
endmodule

// ===== test/tb_top.sv
// Purpose: directed bench for the timer compare block
// Assumes: counter writes only in normal mode with the tick low
// Notes: inputs move on the falling clock edge
`timescale 1ns/1ps
module tb_top import tcw_pkg::*; ;
  logic       clock, srst, count_enable, counter_write, compare_write, force_compare_strobe;
  logic       state_write, state_wdata, overflow_clear, compare_clear, port_data, port_direction;
  logic       overflow_flag, compare_flag_a, channel_a_output_state, pin_out, pin_oe_n, pad_level;
  logic [2:0] waveform_mode_select;
  logic [1:0] channel_a_output_mode_bits;
  logic [7:0] counter_wdata, compare_wdata, counter_value, compare_value_a, compare_buffer_a;
  int         fails, comparisons;
  tcw_timer dut (.*);
  tcw_pin_load load (.pin_out, .pin_oe_n, .pad_level);
  // 25 ns clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Flags widen with zeros, so an unknown still mismatches
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Tick high for n clock edges
  task tick(input int n);
    @(negedge clock);
    count_enable = 1'b1;
    repeat (n) @(negedge clock);
    count_enable = 1'b0;
  endtask
  // One-cycle strobes: write, preset, force, overflow clear, match clear
  task pulse(input logic [4:0] sel);
    @(negedge clock);
    {compare_write, state_write, force_compare_strobe, overflow_clear, compare_clear} = sel;
    @(negedge clock);
    {compare_write, state_write, force_compare_strobe, overflow_clear, compare_clear} = 5'h00;
  endtask
  initial begin
    {srst, count_enable, counter_write, compare_write, force_compare_strobe, state_write} = 6'h20;
    {state_wdata, overflow_clear, compare_clear, port_data, port_direction} = 5'h10;
    {waveform_mode_select, channel_a_output_mode_bits} = {WGM_NORMAL, COM_OFF};
    {counter_wdata, compare_wdata} = 16'h0000;
    repeat (8) @(negedge clock);
    srst = 1'b0;
    chk("counter", COUNT_RESET, counter_value);
    chk("pin enable", 1'b1, pin_oe_n);
    // Preset before the pin drives, then select pin sources
    pulse(5'h08);
    chk("state", 1'b1, channel_a_output_state);
    port_direction = 1'b1;
    repeat (2) @(negedge clock);
    chk("pad", 1'b0, pad_level);
    channel_a_output_mode_bits = COM_TOGGLE;
    repeat (2) @(negedge clock);
    chk("pad", 1'b1, pad_level);
    // Force toggles the state only
    pulse(5'h04);
    chk("state", 1'b0, channel_a_output_state);
    port_data = 1'b1;
    @(negedge clock);
    chk("match flag", 1'b0, compare_flag_a);
    chk("pad", 1'b0, pad_level);
    // Normal count to max and wrap, output mode off
    channel_a_output_mode_bits = COM_OFF;
    @(negedge clock);
    chk("pad", 1'b1, pad_level);
    pulse(5'h08);
    tick(255);
    chk("counter", COUNT_MAX, counter_value);
    chk("overflow", 1'b0, overflow_flag);
    tick(1);
    chk("counter", COUNT_BOTTOM, counter_value);
    chk("overflow", 1'b1, overflow_flag);
    chk("state", 1'b1, channel_a_output_state);
    // Clear on match at 3 with toggle
    pulse(5'h03);
    compare_wdata = 8'h03;
    pulse(5'h10);
    chk("compare", 8'h03, compare_value_a);
    {waveform_mode_select, channel_a_output_mode_bits} = {WGM_CLEAR, COM_TOGGLE};
    tick(4);
    chk("counter", COUNT_BOTTOM, counter_value);
    chk("state", 1'b0, channel_a_output_state);
    @(negedge clock);
    chk("match flag", 1'b1, compare_flag_a);
    // Compare written below the count: run on to max and wrap
    tick(2);
    compare_wdata = 8'h01;
    pulse(5'h10);
    chk("compare", 8'h01, compare_value_a);
    tick(254);
    chk("counter", COUNT_BOTTOM, counter_value);
    chk("overflow", 1'b1, overflow_flag);
    // Fast PWM to max: buffered compare, set at bottom, clear at match
    pulse(5'h02);
    {waveform_mode_select, channel_a_output_mode_bits} = {WGM_FAST_MAX, COM_CLEAR};
    compare_wdata = 8'h80;
    pulse(5'h10);
    chk("compare", 8'h01, compare_value_a);
    chk("buffer", 8'h80, compare_buffer_a);
    tick(FIXED_PERIOD);
    chk("counter", COUNT_BOTTOM, counter_value);
    chk("compare", 8'h80, compare_value_a);
    chk("state", 1'b1, channel_a_output_state);
    chk("overflow", 1'b1, overflow_flag);
    tick(129);
    chk("state", 1'b0, channel_a_output_state);
    // Inverted: clear at bottom, then top from compare A
    channel_a_output_mode_bits = COM_SET;
    tick(127);
    chk("counter", COUNT_BOTTOM, counter_value);
    pulse(5'h02);
    waveform_mode_select = WGM_FAST_A;
    tick(129);
    chk("counter", COUNT_BOTTOM, counter_value);
    chk("state", 1'b1, channel_a_output_state);
    chk("overflow", 1'b1, overflow_flag);
    // Toggle in fast PWM keeps the compare buffered until top
    channel_a_output_mode_bits = COM_TOGGLE;
    compare_wdata = 8'h40;
    pulse(5'h10);
    chk("compare", 8'h80, compare_value_a);
    tick(129);
    chk("state", 1'b0, channel_a_output_state);
    chk("compare", 8'h40, compare_value_a);
    // Counter write in normal mode, then one count from there
    waveform_mode_select = WGM_NORMAL;
    counter_wdata = 8'h20;
    counter_write = 1'b1;
    @(negedge clock);
    counter_write = 1'b0;
    chk("counter", 8'h20, counter_value);
    tick(1);
    chk("counter", 8'h21, counter_value);
    report_and_stop;
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    report_and_stop;
  end
endmodule
